// ### core/bvmc_pkg.sv
`default_nettype none

package bvmc_pkg;

    // ****************************************************************
    // Register map (printed offsets are not word multiples: index * 4)
    // ****************************************************************
    localparam logic [3:0] BVMC_IDX_MODE_CTRL = 4'h0;
    localparam logic [3:0] BVMC_IDX_THRESHOLD = 4'h1;
    localparam logic [3:0] BVMC_IDX_WARN_LEVEL = 4'h8;
    localparam logic [3:0] BVMC_IDX_WARN_WARNING_INTERRUPT_CONTROL = 4'h9;
    localparam logic [3:0] BVMC_IDX_WARN_FLAG = 4'ha;
    localparam logic [3:0] BVMC_IDX_WARN_STATUS = 4'hb;
    localparam logic [3:0] BVMC_IDX_SYS_CTRL = 4'hc;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int BVMC_SLEEP_LSB = 0;
    localparam int BVMC_AWAKE_LSB = 2;
    localparam int BVMC_RATE_BIT = 4;
    localparam int BVMC_IE_BIT = 0;
    localparam int BVMC_DIR_LSB = 1;
    localparam int BVMC_KEY_OPEN_BIT = 0;
    localparam int BVMC_SLEEP_REQ_BIT = 1;

    // ****************************************************************
    // Encodings
    // ****************************************************************
    localparam logic [1:0] BVMC_MODE_OFF = 2'h0;
    localparam logic [1:0] BVMC_MODE_ON = 2'h1;
    localparam logic [1:0] BVMC_MODE_SAMPLED = 2'h2;
    localparam logic [1:0] BVMC_MODE_ON_HOLD = 2'h3;
    localparam logic [1:0] BVMC_DIR_FALL = 2'h0;
    localparam logic [1:0] BVMC_DIR_RISE = 2'h1;
    localparam logic [1:0] BVMC_DIR_BOTH = 2'h2;
    localparam logic [2:0] BVMC_LVL_LOW = 3'h0;
    localparam logic [2:0] BVMC_LVL_MID = 3'h2;
    localparam logic [2:0] BVMC_LVL_HIGH = 3'h7;
    localparam logic [1:0] BVMC_MARGIN_5 = 2'h0;
    localparam logic [1:0] BVMC_MARGIN_15 = 2'h1;
    localparam logic [1:0] BVMC_MARGIN_25 = 2'h2;

    // ****************************************************************
    // Timing: key window and sample periods
    // ****************************************************************
    localparam int BVMC_KEY_WINDOW_CYC = 4;
    localparam int BVMC_CLK_HZ = 25000000;
    localparam int BVMC_FAST_RATE_HZ = 1000;
    localparam int BVMC_SLOW_RATE_HZ = 125;
    localparam int BVMC_FAST_PERIOD_CYC = BVMC_CLK_HZ / BVMC_FAST_RATE_HZ;
    localparam int BVMC_SLOW_PERIOD_CYC = BVMC_CLK_HZ / BVMC_SLOW_RATE_HZ;

    typedef struct packed {
        logic sample_rate_sel;
        logic [1:0] awake_mode;
        logic [1:0] sleep_mode;
        logic [2:0] trip_threshold_field;
    } bvmc_fuse_s;

    typedef enum logic [2:0] {
        BVMC_ST_IDLE = 3'b001,
        BVMC_ST_DATA = 3'b010,
        BVMC_ST_LOAD = 3'b100
    } bvmc_state_e;

endpackage

`default_nettype wire

// ### core/bvmc_ctrl.sv
// The AHB-Lite slave port was decided locally.
`default_nettype none

module bvmc_ctrl (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Fuses and system
    input wire bvmc_pkg::bvmc_fuse_s fuse_in,
    input wire logic key_open_pulse,
    input wire logic sleep_req,
    input wire logic debug_halted,
    // Analog comparators
    input wire logic below_warning_raw,
    input wire logic detector_ready_raw,
    // Analog controls and interrupt
    output logic detector_enable,
    output logic sample_strobe,
    output logic [2:0] trip_level,
    output logic [1:0] warning_margin,
    output logic wake_hold,
    output logic warning_irq
);
    import bvmc_pkg::*;

    typedef struct packed {
        bvmc_state_e st;
        logic [3:0] idx;
        logic wr;
        logic [31:0] rdata;
        logic loaded;
        logic rate;
        logic [1:0] awake_mode;
        logic [1:0] sleep_mode;
        logic [2:0] lvl;
        logic [1:0] margin;
        logic ie;
        logic [1:0] dir;
        logic flag;
        logic status;
        logic [2:0] key_cnt;
        logic [17:0] div_cnt;
        logic [1:0] below_sync;
        logic [1:0] ready_sync;
        logic below_prev;
        logic det_en;
        logic smp;
        logic hold;
        logic irq;
    } bvmc_state_s;

    bvmc_state_s s_q;
    bvmc_state_s s_d;

    logic [1:0] mode_now;
    logic mon_on;
    logic sampled;
    logic eval;
    logic fell;
    logic rose;
    logic cond;
    logic ie_rise;
    logic [17:0] period;
    logic [31:0] rd_val;

    // ****************************************************************
    // Combinational next state
    // ****************************************************************
    always_comb begin
        s_d = s_q;
        s_d.below_sync = {s_q.below_sync[0], below_warning_raw};
        s_d.ready_sync = {s_q.ready_sync[0], detector_ready_raw};
        // Fuses are captured on the first clock after reset release.
        if (!s_q.loaded) begin
            s_d.loaded = 1'b1;
            s_d.rate = fuse_in.sample_rate_sel;
            s_d.awake_mode = fuse_in.awake_mode;
            s_d.sleep_mode = fuse_in.sleep_mode;
            s_d.lvl = fuse_in.trip_threshold_field;
        end
        // Key window counts down the cycles left for a protected write.
        if (key_open_pulse) begin
            s_d.key_cnt = 3'(BVMC_KEY_WINDOW_CYC);
        end else if (s_q.key_cnt != 3'h0) begin
            s_d.key_cnt = s_q.key_cnt - 3'h1;
        end

        mode_now = sleep_req ? s_q.sleep_mode : s_q.awake_mode;
        // No mode code is reserved: every code except off (on, sampled, on-hold) enables the detector.
        mon_on = (mode_now == BVMC_MODE_ON) || (mode_now == BVMC_MODE_ON_HOLD)
            || (mode_now == BVMC_MODE_SAMPLED);
        sampled = mode_now == BVMC_MODE_SAMPLED;
        period = s_q.rate ? 18'(BVMC_SLOW_PERIOD_CYC) : 18'(BVMC_FAST_PERIOD_CYC);
        s_d.smp = 1'b0;
        if (!sampled || s_q.div_cnt >= period - 18'h1) begin
            s_d.div_cnt = 18'h0;
            s_d.smp = sampled;
        end else begin
            s_d.div_cnt = s_q.div_cnt + 18'h1;
        end
        eval = mon_on && (!sampled || s_q.smp);
        s_d.det_en = mon_on;
        s_d.hold = (mode_now == BVMC_MODE_ON_HOLD) && !s_q.ready_sync[1];

        fell = eval && s_q.below_sync[1] && !s_q.below_prev;
        rose = eval && !s_q.below_sync[1] && s_q.below_prev;
        if (eval) begin
            s_d.below_prev = s_q.below_sync[1];
            s_d.status = s_q.below_sync[1];
        end
        if (!mon_on) begin
            s_d.status = 1'b0;
        end

        if (sampled) begin
            cond = rose && (s_q.dir == BVMC_DIR_RISE);
        end else begin
            unique case (s_q.dir)
                BVMC_DIR_FALL: cond = fell;
                BVMC_DIR_RISE: cond = rose;
                BVMC_DIR_BOTH: cond = fell || rose;
                default: cond = 1'b0;
            endcase
        end
        ie_rise = 1'b0;

        // Bus: address phase captured, data phase applied one cycle later.
        unique case (s_q.st)
            BVMC_ST_DATA: begin
                if (s_q.wr) begin
                    unique case (s_q.idx)
                        BVMC_IDX_MODE_CTRL: begin
                            if (s_q.key_cnt != 3'h0) begin
                                s_d.sleep_mode = hwdata[BVMC_SLEEP_LSB +: 2];
                            end
                        end
                        BVMC_IDX_WARN_LEVEL: s_d.margin = hwdata[1:0];
                        BVMC_IDX_WARN_WARNING_INTERRUPT_CONTROL: begin
                            s_d.ie = hwdata[BVMC_IE_BIT];
                            s_d.dir = hwdata[BVMC_DIR_LSB +: 2];
                            ie_rise = hwdata[BVMC_IE_BIT] && !s_q.ie;
                        end
                        BVMC_IDX_WARN_FLAG: begin
                            if (hwdata[0]) begin
                                s_d.flag = 1'b0;
                            end
                        end
                        default: ;
                    endcase
                end
                s_d.st = BVMC_ST_IDLE;
            end
            default: s_d.st = BVMC_ST_IDLE;
        endcase
        if (hsel && hready && htrans[1]) begin
            s_d.st = BVMC_ST_DATA;
            s_d.idx = haddr[5:2];
            s_d.wr = hwrite;
        end

        // Enabling with direction both reports at once; set beats clear.
        if (mon_on && (cond || (ie_rise && s_d.dir == BVMC_DIR_BOTH))) begin
            s_d.flag = 1'b1;
        end
        s_d.irq = s_d.ie && s_d.flag && !debug_halted;

        rd_val = 32'h0;
        unique case (s_d.idx)
            BVMC_IDX_MODE_CTRL: rd_val = {27'h0, s_d.rate, s_d.awake_mode, s_d.sleep_mode};
            BVMC_IDX_THRESHOLD: rd_val = {29'h0, s_d.lvl};
            BVMC_IDX_WARN_LEVEL: rd_val = {30'h0, s_d.margin};
            BVMC_IDX_WARN_WARNING_INTERRUPT_CONTROL: rd_val = {29'h0, s_d.dir, s_d.ie};
            BVMC_IDX_WARN_FLAG: rd_val = {31'h0, s_d.flag};
            BVMC_IDX_WARN_STATUS: rd_val = {31'h0, s_d.status};
            BVMC_IDX_SYS_CTRL: rd_val = {30'h0, sleep_req, s_q.key_cnt != 3'h0};
            default: rd_val = 32'h0;
        endcase
        s_d.rdata = (s_d.st == BVMC_ST_DATA && !s_d.wr) ? rd_val : 32'h0;
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
            s_q.st <= BVMC_ST_LOAD;
        end else begin
            s_q <= s_d;
        end
    end

    assign hrdata = s_q.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign detector_enable = s_q.det_en;
    assign sample_strobe = s_q.smp;
    assign trip_level = s_q.lvl;
    assign warning_margin = s_q.margin;
    assign wake_hold = s_q.hold;
    assign warning_irq = s_q.irq;

endmodule

`default_nettype wire

// ### verif/bvmc_ctrl_monitor.sv
`default_nettype none
module bvmc_ctrl_monitor import bvmc_pkg::*; (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Device side
    input wire bvmc_pkg::bvmc_fuse_s fuse_in,
    input wire logic debug_halted,
    input wire logic sample_strobe,
    input wire logic [2:0] trip_level,
    input wire logic [1:0] warning_margin,
    input wire logic wake_hold,
    input wire logic warning_irq
);
    // ****************************************
    // Data-phase tracking
    // ****************************************
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    logic wr_q;
    logic rd_q;
    logic [31:0] addr_q;
    logic [1:0] mg_q;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            addr_q <= 32'h0;
            mg_q <= 2'h0;
        end else begin
            wr_q <= hsel & hready & htrans[1] & hwrite;
            rd_q <= hsel & hready & htrans[1] & !hwrite;
            addr_q <= haddr;
            if (wr_q && addr_q == 32'h20) begin
                mg_q <= hwdata[1:0];
            end
        end
    end
    property p_ready; hreadyout; endproperty
    a_ready: assert property (p_ready) else $error("slave stalled");
    property p_okay; !hresp; endproperty
    a_okay: assert property (p_okay) else $error("error response");
    property p_rdata; hrdata != 32'h0 |-> rd_q; endproperty
    a_rdata: assert property (p_rdata) else $error("read data outside data phase");
    property p_margin; wr_q && addr_q == 32'h20 |-> ##[1:2] warning_margin == mg_q; endproperty
    a_margin: assert property (p_margin) else $error("margin not applied");
    property p_irq_dbg; debug_halted && $past(debug_halted) |-> !warning_irq; endproperty
    a_irq_dbg: assert property (p_irq_dbg) else $error("irq while halted");
    property p_trip; $past(reset_n, 2) |-> trip_level == fuse_in.trip_threshold_field; endproperty
    a_trip: assert property (p_trip) else $error("trip level not from fuse");
    property p_hold; wake_hold |-> fuse_in.awake_mode == BVMC_MODE_ON_HOLD; endproperty
    a_hold: assert property (p_hold) else $error("wake hold in wrong mode");
    property p_strobe; sample_strobe |=> !sample_strobe; endproperty
    a_strobe: assert property (p_strobe) else $error("sample strobe too long");
endmodule
bind bvmc_ctrl bvmc_ctrl_monitor u_mon (.clk_sys, .reset_n, .hsel, .haddr, .htrans, .hwrite,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .fuse_in, .debug_halted, .sample_strobe,
    .trip_level, .warning_margin, .wake_hold, .warning_irq);
`default_nettype wire

// ### verif/bvmc_ctrl_bench.sv
`default_nettype none
module bvmc_ctrl_bench import bvmc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Stimulus and design
    // ****************************************
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic hsel = 1'b1, hwrite = 1'b0, key_open_pulse = 1'b0, sleep_req = 1'b0;
    logic debug_halted = 1'b0, below_warning_raw = 1'b0, detector_ready_raw = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'h0, warning_margin;
    logic [2:0] hsize = 3'h2, trip_level;
    logic hready, hreadyout, hresp, detector_enable, sample_strobe, wake_hold, warning_irq;
    bvmc_fuse_s fuse_in = {1'b0, BVMC_MODE_ON_HOLD, BVMC_MODE_SAMPLED, BVMC_LVL_HIGH};
    int error_cnt = 0, n_checks = 0, cyc = 0, t0;
    // The only slave's ready is the bus ready.
    assign hready = hreadyout;
    always #20 clk_sys = ~clk_sys;
    bvmc_ctrl dut (.clk_sys, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hrdata, .hreadyout, .hresp, .fuse_in, .key_open_pulse, .sleep_req,
        .debug_halted, .below_warning_raw, .detector_ready_raw, .detector_enable,
        .sample_strobe, .trip_level, .warning_margin, .wake_hold, .warning_irq);
    task automatic tally_and_finish;
        if (error_cnt == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // Called right after an edge; hsel stays high so only htrans marks a request.
    task automatic xfer(input logic w, input logic [3:0] idx, input logic [31:0] wd);
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {26'h0, idx, 2'h0};
        do @(posedge clk_sys); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_sys); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rdchk(input logic [3:0] idx, input logic [31:0] exp);
        xfer(1'b0, idx, 32'h0);
        chk(rd, exp);
    endtask
    task automatic keyed_sleep(input logic [31:0] code);
        key_open_pulse <= 1'b1;
        step(1);
        key_open_pulse <= 1'b0;
        xfer(1'b1, BVMC_IDX_MODE_CTRL, code);
    endtask
    task automatic wstrobe;
        do @(posedge clk_sys); while (sample_strobe !== 1'b1);
    endtask
    initial begin
        step(3);
        reset_n <= 1'b1;
        step(2);
        rdchk(BVMC_IDX_MODE_CTRL, 32'he);
        rdchk(BVMC_IDX_THRESHOLD, 32'h7);
        chk(32'(trip_level), 32'h7);
        for (int i = 8; i < 12; i++) rdchk(4'(i), 32'h0);
        xfer(1'b1, BVMC_IDX_MODE_CTRL, 32'hff);
        rdchk(BVMC_IDX_MODE_CTRL, 32'he);
        xfer(1'b1, BVMC_IDX_THRESHOLD, 32'h0);
        rdchk(BVMC_IDX_THRESHOLD, 32'h7);
        xfer(1'b1, 4'h3, 32'hff);
        rdchk(4'h3, 32'h0);
        chk(32'(wake_hold), 32'h1);
        detector_ready_raw <= 1'b1;
        step(4);
        chk(32'(wake_hold), 32'h0);
        xfer(1'b1, BVMC_IDX_WARN_LEVEL, 32'h2);
        rdchk(BVMC_IDX_WARN_LEVEL, 32'h2);
        keyed_sleep(32'h1);
        rdchk(BVMC_IDX_MODE_CTRL, 32'hd);
        xfer(1'b1, BVMC_IDX_WARN_WARNING_INTERRUPT_CONTROL, 32'h5);
        step(4);
        rdchk(BVMC_IDX_WARN_FLAG, 32'h1);
        chk(32'(warning_irq), 32'h1);
        debug_halted <= 1'b1;
        step(3);
        chk(32'(warning_irq), 32'h0);
        debug_halted <= 1'b0;
        step(3);
        chk(32'(warning_irq), 32'h1);
        xfer(1'b1, BVMC_IDX_WARN_FLAG, 32'h1);
        rdchk(BVMC_IDX_WARN_FLAG, 32'h0);
        chk(32'(warning_irq), 32'h0);
        xfer(1'b1, BVMC_IDX_WARN_WARNING_INTERRUPT_CONTROL, 32'h1);
        rdchk(BVMC_IDX_WARN_FLAG, 32'h0);
        below_warning_raw <= 1'b1;
        step(6);
        rdchk(BVMC_IDX_WARN_STATUS, 32'h1);
        rdchk(BVMC_IDX_WARN_FLAG, 32'h1);
        xfer(1'b1, BVMC_IDX_WARN_FLAG, 32'h1);
        xfer(1'b1, BVMC_IDX_WARN_WARNING_INTERRUPT_CONTROL, 32'h2);
        below_warning_raw <= 1'b0;
        step(6);
        rdchk(BVMC_IDX_WARN_FLAG, 32'h1);
        chk(32'(warning_irq), 32'h0);
        xfer(1'b1, BVMC_IDX_WARN_FLAG, 32'h1);
        keyed_sleep(32'h0);
        xfer(1'b1, BVMC_IDX_WARN_WARNING_INTERRUPT_CONTROL, 32'h4);
        sleep_req <= 1'b1;
        step(4);
        chk(32'(detector_enable), 32'h0);
        below_warning_raw <= 1'b1;
        step(6);
        rdchk(BVMC_IDX_WARN_FLAG, 32'h0);
        sleep_req <= 1'b0;
        step(4);
        chk(32'(detector_enable), 32'h1);
        keyed_sleep(32'h2);
        sleep_req <= 1'b1;
        wstrobe();
        t0 = cyc;
        wstrobe();
        chk(32'(cyc - t0), 32'(BVMC_FAST_PERIOD_CYC));
        tally_and_finish();
    end
endmodule
`default_nettype wire
